// ### icm_timer.sv
// The register addresses and register access over Wishbone were decided locally.
`default_nettype none
// Functional notes
// - Toggle pin at modulo when toggle enabled.
// - Compare drives pin inactive; overflow-to-compare is width.
// - Modulo 255, prescale 0 gives 256 clocks.
// - Overflow sets flag; interrupt only when enabled.
// - Capture or compare sets channel flag.
// - Channel enable gates DMA; select routes request.
// - Wait: keep counting, block bus, wake.
// - Stop: counter, prescaler, capture and compare freeze and keep their state, but bus accesses still take effect.
// - Break halts the counter.
// - Break: flags clearable only with clear-enable.
// - Armed clear survives break, completes after.
// - Per-channel capture/compare; channel 0 buffered.
// - Select 00: mode A sets initial level.
// - Select 00 disconnects channel from pin.
// - Select bits choose capture edge or action.
// - Max-duty forces 100% from next period.
// - Capture: high read blocks until low read.
// - Compare: high write blocks until low write.
// - Channel values read/write, no reset value.
module icm_timer #(
  parameter int NCH = 3,
  parameter int PRE_W = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic brk_active,
  input wire logic break_clear_enable,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic [NCH-1:0] channel_pin_in,
  output logic [NCH-1:0] channel_pin_out,
  output logic [NCH-1:0] channel_pin_oe_n,
  output logic overflow_irq,
  output logic [NCH-1:0] channel_irq,
  output logic [NCH-1:0] channel_dma_req,
  output logic wake_req
);
  logic [7:0] sc_reg;
  logic [15:0] mod_reg;
  logic [15:0] cnt_reg;
  logic [NCH-1:0] dma_reg;
  logic [PRE_W-1:0] pre_reg;
  logic ovf_arm_reg;
  icm_pkg::icm_chctl_s ctl_reg [NCH];
  logic [15:0] val_reg [NCH];
  logic [15:0] cmp_reg [NCH];
  logic [NCH-1:0] arm_reg, rd_lock_reg, wr_lock_reg, prev_reg, max_on_reg;
  logic [NCH-1:0] cap_evt, cmp_evt, ch_req;
  logic acc, wr, rd, brk_lock, run, tick, ovf, cnt_clr, ovf_clr;
  logic [7:0] wd;
  logic [PRE_W-1:0] mask;
  logic [31:0] rdata;

  // Bus qualifiers; in wait mode the bus is answered but has no effect.
  assign acc = wb_cyc_i & wb_stb_i & ~wait_mode;
  assign wr = acc & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_ack_o & ~wb_we_i;
  assign wd = wb_dat_i[7:0];
  assign brk_lock = brk_active & ~break_clear_enable;
  // Counter runs unless halted, in break or in stop.
  assign run = ~sc_reg[icm_pkg::SC_HALT] & ~brk_active & ~stop_mode;
  assign mask = PRE_W'((1 << sc_reg[icm_pkg::SC_PS_HI:0]) - 1);
  assign tick = run & ((pre_reg & mask) == mask);
  assign ovf = tick & (cnt_reg == mod_reg);
  assign cnt_clr = wr & (wb_adr_i == icm_pkg::OFS_SC) & wd[icm_pkg::SC_CLR];
  assign ovf_clr = wr & (wb_adr_i == icm_pkg::OFS_SC) & ~wd[icm_pkg::SC_OVF] & ovf_arm_reg & ~brk_lock;
  // Wishbone acknowledge and read data, one wait state per access.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
        wb_dat_o <= wait_mode ? 32'h0000_0000 : rdata;
    end
  end
  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      icm_pkg::OFS_SC: rdata[7:0] = sc_reg;
      icm_pkg::OFS_MODH: rdata[7:0] = mod_reg[15:8];
      icm_pkg::OFS_MODL: rdata[7:0] = mod_reg[7:0];
      icm_pkg::OFS_CNTH: rdata[7:0] = cnt_reg[15:8];
      icm_pkg::OFS_CNTL: rdata[7:0] = cnt_reg[7:0];
      icm_pkg::OFS_DMA: rdata[NCH-1:0] = dma_reg;
      default: rdata = 32'h0000_0000;
    endcase
    for (int k = 0; k < NCH; k++)
    begin
      if (wb_adr_i == icm_pkg::OFS_CH0 + 8'(k) * icm_pkg::CH_STRIDE + icm_pkg::CH_SC)
        rdata[7:0] = ctl_reg[k];
      if (wb_adr_i == icm_pkg::OFS_CH0 + 8'(k) * icm_pkg::CH_STRIDE + icm_pkg::CH_VH)
        rdata[7:0] = val_reg[k][15:8];
      if (wb_adr_i == icm_pkg::OFS_CH0 + 8'(k) * icm_pkg::CH_STRIDE + icm_pkg::CH_VL)
        rdata[7:0] = val_reg[k][7:0];
    end
  end
  // Prescaler divides the bus clock by two to the select value.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pre_reg <= '0;
    else if (cnt_clr)
      pre_reg <= '0;
    else if (run)
      pre_reg <= pre_reg + PRE_W'(1);
  end
  // Counter wraps to zero on the tick after it equals modulo.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= icm_pkg::CNT_RST;
    else if (cnt_clr)
      cnt_reg <= icm_pkg::CNT_RST;
    else if (tick)
      cnt_reg <= ovf ? icm_pkg::CNT_RST : cnt_reg + 16'h0001;
  end
  // Modulo and DMA select registers.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mod_reg <= icm_pkg::MOD_RST;
      dma_reg <= '0;
    end
    else
    begin
      if (wr & (wb_adr_i == icm_pkg::OFS_MODH))
        mod_reg[15:8] <= wd;
      if (wr & (wb_adr_i == icm_pkg::OFS_MODL))
        mod_reg[7:0] <= wd;
      if (wr & (wb_adr_i == icm_pkg::OFS_DMA))
        dma_reg <= wd[NCH-1:0];
    end
  end
  // Status and control; overflow set wins over clear.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sc_reg <= icm_pkg::SC_RST;
      ovf_arm_reg <= 1'b0;
    end
    else
    begin
      if (wr & (wb_adr_i == icm_pkg::OFS_SC))
      begin
        sc_reg[icm_pkg::SC_OIE:icm_pkg::SC_HALT] <= wd[icm_pkg::SC_OIE:icm_pkg::SC_HALT];
        sc_reg[icm_pkg::SC_PS_HI:0] <= wd[icm_pkg::SC_PS_HI:0];
      end
      if (ovf)
        sc_reg[icm_pkg::SC_OVF] <= 1'b1;
      else if (ovf_clr)
        sc_reg[icm_pkg::SC_OVF] <= 1'b0;
      if (ovf_clr)
        ovf_arm_reg <= 1'b0;
      else if (rd & (wb_adr_i == icm_pkg::OFS_SC) & sc_reg[icm_pkg::SC_OVF] & ~brk_lock)
        ovf_arm_reg <= 1'b1;
    end
  end

  // Channel slices.
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    localparam logic [7:0] BASE = icm_pkg::OFS_CH0 + 8'(i) * icm_pkg::CH_STRIDE;
    logic cap_mode, buffered, rise, fall, wr_sc, flag_clr, pin_act;
    logic [15:0] cmp_use;
    assign cap_mode = ~ctl_reg[i].msb & ~ctl_reg[i].msa;
    assign buffered = (i == 0) & ctl_reg[i].msb;
    assign cmp_use = buffered ? cmp_reg[i] : val_reg[i];
    assign rise = channel_pin_in[i] & ~prev_reg[i];
    assign fall = ~channel_pin_in[i] & prev_reg[i];
    // Capture edges and compare match, each with its byte interlock.
    assign cap_evt[i] = cap_mode & ~rd_lock_reg[i] & ~stop_mode
      & ((ctl_reg[i].els[0] & rise) | (ctl_reg[i].els[1] & fall));
    assign cmp_evt[i] = ~cap_mode & ~wr_lock_reg[i] & tick & (cnt_reg == cmp_use)
      & (ctl_reg[i].els != icm_pkg::ELS_OFF);
    assign wr_sc = wr & (wb_adr_i == BASE + icm_pkg::CH_SC);
    assign flag_clr = wr_sc & ~wd[7] & arm_reg[i] & ~brk_lock;
    assign pin_act = (ctl_reg[i].els == icm_pkg::ELS_FALL_CLR);
    assign ch_req[i] = ctl_reg[i].flag & ctl_reg[i].ie;

    // Control bits, flag and read-then-write clear arming.
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        ctl_reg[i] <= icm_pkg::CHCTL_RST;
        arm_reg[i] <= 1'b0;
      end
      else
      begin
        if (wr_sc)
          ctl_reg[i][6:0] <= wd[6:0];
        if (cap_evt[i] | cmp_evt[i])
          ctl_reg[i].flag <= 1'b1;
        else if (flag_clr)
          ctl_reg[i].flag <= 1'b0;
        if (flag_clr)
          arm_reg[i] <= 1'b0;
        else if (rd & (wb_adr_i == BASE + icm_pkg::CH_SC) & ctl_reg[i].flag & ~brk_lock)
          arm_reg[i] <= 1'b1;
      end
    end

    // Value register: captured count or compare value, no reset.
    always_ff @(posedge core_clk)
    begin
      if (cap_evt[i])
        val_reg[i] <= cnt_reg;
      else
      begin
        if (wr & (wb_adr_i == BASE + icm_pkg::CH_VH))
          val_reg[i][15:8] <= wd;
        if (wr & (wb_adr_i == BASE + icm_pkg::CH_VL))
          val_reg[i][7:0] <= wd;
      end
      if (~buffered | ovf)
        cmp_reg[i] <= val_reg[i];
    end

    // Byte-order interlocks and pin history.
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        rd_lock_reg[i] <= 1'b0;
        wr_lock_reg[i] <= 1'b0;
        prev_reg[i] <= 1'b0;
      end
      else
      begin
        prev_reg[i] <= channel_pin_in[i];
        if (rd & (wb_adr_i == BASE + icm_pkg::CH_VL))
          rd_lock_reg[i] <= 1'b0;
        else if (rd & cap_mode & (wb_adr_i == BASE + icm_pkg::CH_VH))
          rd_lock_reg[i] <= 1'b1;
        if (wr & (wb_adr_i == BASE + icm_pkg::CH_VL))
          wr_lock_reg[i] <= 1'b0;
        else if (wr & ~cap_mode & (wb_adr_i == BASE + icm_pkg::CH_VH))
          wr_lock_reg[i] <= 1'b1;
      end
    end
    // Pin driver: initial level, overflow toggle, compare action; leaving full duty restarts at the active level.
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        channel_pin_out[i] <= 1'b1;
        channel_pin_oe_n[i] <= 1'b1;
        max_on_reg[i] <= 1'b0;
      end
      else
      begin
        channel_pin_oe_n[i] <= (ctl_reg[i].els == icm_pkg::ELS_OFF) | cap_mode;
        if (ctl_reg[i].els == icm_pkg::ELS_OFF)
        begin
          channel_pin_out[i] <= ~ctl_reg[i].msa;
          max_on_reg[i] <= 1'b0;
        end
        else if (~cap_mode & ovf & ctl_reg[i].tov)
        begin
          max_on_reg[i] <= ctl_reg[i].mx;
          if ((ctl_reg[i].mx | max_on_reg[i]) & (ctl_reg[i].els != icm_pkg::ELS_RISE_TOG))
            channel_pin_out[i] <= pin_act;
          else
            channel_pin_out[i] <= ~channel_pin_out[i];
        end
        else if (cmp_evt[i] & ~(max_on_reg[i] & ctl_reg[i].tov))
        begin
          case (ctl_reg[i].els)
            icm_pkg::ELS_RISE_TOG: channel_pin_out[i] <= ~channel_pin_out[i];
            icm_pkg::ELS_FALL_CLR: channel_pin_out[i] <= 1'b0;
            icm_pkg::ELS_BOTH_SET: channel_pin_out[i] <= 1'b1;
            default: channel_pin_out[i] <= channel_pin_out[i];
          endcase
        end
      end
    end
  end
  // Requests: CPU or DMA per channel, and wake from wait.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      overflow_irq <= 1'b0;
      channel_irq <= '0;
      channel_dma_req <= '0;
      wake_req <= 1'b0;
    end
    else
    begin
      overflow_irq <= sc_reg[icm_pkg::SC_OVF] & sc_reg[icm_pkg::SC_OIE];
      channel_irq <= ch_req & ~dma_reg;
      channel_dma_req <= ch_req & dma_reg;
      wake_req <= (sc_reg[icm_pkg::SC_OVF] & sc_reg[icm_pkg::SC_OIE]) | (|(ch_req & ~dma_reg));
    end
  end
  // Assertions sample on the bus clock and rest during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_wrap;
    ovf & ~cnt_clr |=> cnt_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_ovf_irq;
    ovf & sc_reg[icm_pkg::SC_OIE] & ~wr |=> ##1 overflow_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");
  property p_brk_hold;
    brk_active & ~cnt_clr |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("counter moved in break");
  property p_stop_hold;
    stop_mode & ~cnt_clr & ~ovf_clr |=> $stable(cnt_reg) && $stable(sc_reg[icm_pkg::SC_OVF]);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop");
  property p_flag_set;
    cap_evt[1] |=> ctl_reg[1].flag && val_reg[1] == $past(cnt_reg);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("capture not recorded");
  property p_cap_block;
    rd_lock_reg[1] |-> ~cap_evt[1];
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("capture while locked");
  property p_cmp_block;
    wr_lock_reg[0] |-> ~cmp_evt[0];
  endproperty
  a_cmp_block: assert property (p_cmp_block) else $error("compare while locked");
  property p_brk_flag;
    brk_lock & ctl_reg[0].flag |=> ctl_reg[0].flag;
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("flag cleared in break");
  property p_disc;
    ctl_reg[1].els == icm_pkg::ELS_OFF |=> channel_pin_oe_n[1];
  endproperty
  a_disc: assert property (p_disc) else $error("pin driven while disconnected");
  property p_dma;
    ch_req[1] & dma_reg[1] |=> channel_dma_req[1] & ~channel_irq[1];
  endproperty
  a_dma: assert property (p_dma) else $error("dma routing wrong");
  c_ovf: cover property (ovf ##1 overflow_irq);
  c_cap: cover property (cap_evt[1]);
  c_cmp: cover property (cmp_evt[1] ##1 ctl_reg[1].flag);
  c_max: cover property (max_on_reg[0] & ovf);
endmodule // icm_timer
`default_nettype wire

// ### icm_pkg.sv
`default_nettype none
// Shared constants and carriers for the interval counter module.
package icm_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_SC = 8'h00;
  localparam logic [7:0] OFS_MODH = 8'h04;
  localparam logic [7:0] OFS_MODL = 8'h08;
  localparam logic [7:0] OFS_CNTH = 8'h0C;
  localparam logic [7:0] OFS_CNTL = 8'h10;
  localparam logic [7:0] OFS_DMA = 8'h14;
  localparam logic [7:0] OFS_CH0 = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_SC = 8'h00;
  localparam logic [7:0] CH_VH = 8'h04;
  localparam logic [7:0] CH_VL = 8'h08;
  // Field positions in the counter status and control register.
  localparam int SC_OVF = 7;
  localparam int SC_OIE = 6;
  localparam int SC_HALT = 5;
  localparam int SC_CLR = 4;
  localparam int SC_PS_HI = 2;
  // Reset values.
  localparam logic [7:0] SC_RST = 8'h20;
  localparam logic [15:0] MOD_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] CHCTL_RST = 8'h00;
  // Edge/level select encodings.
  typedef enum logic [1:0] {
    ELS_OFF = 2'h0,
    ELS_RISE_TOG = 2'h1,
    ELS_FALL_CLR = 2'h2,
    ELS_BOTH_SET = 2'h3
  } icm_els_e;
  // Channel status and control register, in bit order 7 down to 0.
  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    icm_els_e els;
    logic tov;
    logic mx;
  } icm_chctl_s;
endpackage : icm_pkg
`default_nettype wire

// ### icm_pin_model.sv
`default_nettype none
// External circuit on the shared channel pins.
module icm_pin_model #(
  parameter int NCH = 3
) (
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe_n,
  input wire logic [NCH-1:0] ext_level,
  output logic [NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin reads back the block's level; a released pin follows the outside source.
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule // icm_pin_model
`default_nettype wire

// ### icm_timer_test.sv
`default_nettype none
// Register-level test of the interval counter channels.
module icm_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic brk = 1'b0;
  logic bce = 1'b0;
  logic wt = 1'b0;
  logic stp = 1'b0;
  logic [2:0] ext = 3'h0;
  logic [2:0] pin_in, pin_out, oe_n, ch_irq, dma;
  logic ovf_irq, wake;
  logic [7:0] d, e, h, l;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n, m;

  icm_timer #(.NCH(3), .PRE_W(7)) dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .brk_active(brk), .break_clear_enable(bce), .wait_mode(wt), .stop_mode(stp),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n),
    .overflow_irq(ovf_irq), .channel_irq(ch_irq), .channel_dma_req(dma), .wake_req(wake));

  icm_pin_model #(.NCH(3)) far (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_level(ext), .pin_in(pin_in));

  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;

  // A hung run is cut short and counted as a mismatch.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // One classic bus cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat_i <= {24'h0, wd};
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] x;
    wb(1'b1, a, wd, x);
  endtask

  task automatic rdb(input logic [7:0] a, output logic [7:0] rd);
    wb(1'b0, a, 8'h00, rd);
  endtask

  function automatic logic [7:0] ca(input int c, input logic [7:0] off);
    return icm_pkg::OFS_CH0 + 8'(icm_pkg::CH_STRIDE * c) + off;
  endfunction

  // Counts cycles until channel 0 reaches the given level, at most 2000.
  task automatic wait_pin(input logic lvl, output int k);
    k = 0;
    while (pin_out[0] !== lvl && k < 2000)
    begin
      @(posedge core_clk);
      k++;
    end
  endtask

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdb(icm_pkg::OFS_SC, d);
    chk(d, icm_pkg::SC_RST);
    rdb(ca(0, icm_pkg::CH_SC), d);
    chk(d, icm_pkg::CHCTL_RST);
    rdb(icm_pkg::OFS_MODL, d);
    chk(d, icm_pkg::MOD_RST[7:0]);
    chk({pin_out[2], oe_n[2]}, 16'h3);
    rdb(8'hFC, d);
    chk(d, 8'h00);
    // Select 00 with mode A set gives a low initial level, still undriven.
    wr(ca(2, icm_pkg::CH_SC), 8'h10);
    repeat (3) @(posedge core_clk);
    chk({pin_out[2], oe_n[2]}, 16'h1);
    // PWM on channel 0: period 256, high from the 0xFF overflow to the 0x40 compare, 65 counts.
    wr(icm_pkg::OFS_SC, 8'h30);
    wr(icm_pkg::OFS_MODH, 8'h00);
    wr(icm_pkg::OFS_MODL, 8'hFF);
    wr(ca(0, icm_pkg::CH_SC), 8'h1A);
    wr(ca(0, icm_pkg::CH_VH), 8'h00);
    wr(ca(0, icm_pkg::CH_VL), 8'h40);
    wr(icm_pkg::OFS_SC, 8'h10);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    wait_pin(1'b1, m);
    chk(16'(n), 16'd65);
    chk(16'(n + m), 16'd256);
    chk(oe_n[0], 1'b0);
    // Maximum duty keeps the pin at its active level.
    wr(ca(0, icm_pkg::CH_SC), 8'h1B);
    repeat (600) @(posedge core_clk);
    wait_pin(1'b0, n);
    chk(16'(n), 16'd2000);
    wr(ca(0, icm_pkg::CH_SC), 8'h1A);
    wait_pin(1'b0, n);
    chk(pin_out[0], 1'b0);
    // Normal PWM resumes: the low part of the period is 256 - 65 counts.
    wait_pin(1'b1, m);
    chk(16'(m), 16'd191);
    // Break freezes the counter.
    brk <= 1'b1;
    rdb(icm_pkg::OFS_CNTL, d);
    repeat (20) @(posedge core_clk);
    rdb(icm_pkg::OFS_CNTL, e);
    chk(e, d);
    // Halt and clear while frozen, so no overflow lands on the flag steps below.
    wr(icm_pkg::OFS_SC, 8'h30);
    brk <= 1'b0;
    // Overflow flag, its interrupt enable and the two-step clear.
    rdb(icm_pkg::OFS_SC, d);
    chk(d[7], 1'b1);
    chk(ovf_irq, 1'b0);
    wr(icm_pkg::OFS_SC, 8'h40);
    rdb(icm_pkg::OFS_SC, d);
    chk(d[7], 1'b0);
    repeat (300) @(posedge core_clk);
    chk(ovf_irq, 1'b1);
    wr(icm_pkg::OFS_SC, 8'hE0);
    rdb(icm_pkg::OFS_SC, d);
    chk(d[7], 1'b1);
    brk <= 1'b1;
    wr(icm_pkg::OFS_SC, 8'h60);
    rdb(icm_pkg::OFS_SC, d);
    chk(d[7], 1'b1);
    brk <= 1'b0;
    wr(icm_pkg::OFS_SC, 8'h60);
    rdb(icm_pkg::OFS_SC, d);
    chk(d[7], 1'b0);
    repeat (3) @(posedge core_clk);
    chk(ovf_irq, 1'b0);
    // Rising-edge capture on channel 1 with the counter halted.
    wr(ca(1, icm_pkg::CH_SC), 8'h44);
    ext[1] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdb(ca(1, icm_pkg::CH_SC), d);
    chk(d[7], 1'b1);
    chk({ch_irq[1], dma[1], oe_n[1]}, 16'h5);
    rdb(icm_pkg::OFS_CNTH, h);
    rdb(icm_pkg::OFS_CNTL, l);
    rdb(ca(1, icm_pkg::CH_VH), d);
    rdb(ca(1, icm_pkg::CH_VL), e);
    chk({d, e}, {h, l});
    wr(icm_pkg::OFS_DMA, 8'h02);
    repeat (3) @(posedge core_clk);
    chk({ch_irq[1], dma[1]}, 16'h1);
    // With clear-enable set, an armed flag clears in break and stays clear.
    bce <= 1'b1;
    brk <= 1'b1;
    wr(ca(1, icm_pkg::CH_SC), 8'h44);
    brk <= 1'b0;
    bce <= 1'b0;
    rdb(ca(1, icm_pkg::CH_SC), d);
    chk(d[7], 1'b0);
    // A high-byte read holds off new captures until the low byte is read.
    wr(icm_pkg::OFS_SC, 8'h40);
    rdb(ca(1, icm_pkg::CH_VH), d);
    ext[1] <= 1'b0;
    repeat (30) @(posedge core_clk);
    ext[1] <= 1'b1;
    repeat (30) @(posedge core_clk);
    rdb(ca(1, icm_pkg::CH_VL), e);
    chk(e, l);
    // Falling-edge selection captures on the pin's drop.
    wr(ca(1, icm_pkg::CH_SC), 8'h48);
    ext[1] <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdb(ca(1, icm_pkg::CH_SC), d);
    chk(d[7], 1'b1);
    // Wait mode hides the registers while counting goes on.
    wt <= 1'b1;
    rdb(icm_pkg::OFS_SC, d);
    chk(d, 8'h00);
    repeat (300) @(posedge core_clk);
    chk(wake, 1'b1);
    wt <= 1'b0;
    // Stop mode freezes the counter.
    stp <= 1'b1;
    rdb(icm_pkg::OFS_CNTL, d);
    repeat (20) @(posedge core_clk);
    rdb(icm_pkg::OFS_CNTL, e);
    chk(e, d);
    stp <= 1'b0;
    // Buffered compare on channel 0 keeps the old 0x40 value until the next overflow.
    wr(icm_pkg::OFS_SC, 8'h30);
    wr(ca(0, icm_pkg::CH_SC), 8'h00);
    wr(ca(0, icm_pkg::CH_SC), 8'h2A);
    wr(ca(0, icm_pkg::CH_VH), 8'h00);
    wr(ca(0, icm_pkg::CH_VL), 8'h80);
    wr(icm_pkg::OFS_SC, 8'h10);
    wait_pin(1'b0, n);
    chk(16'(n), 16'd66);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    chk(16'(n), 16'd129);
    give_verdict();
  end
endmodule // icm_timer_test
`default_nettype wire
